// file: hdl/riv_defines.svh
/*
 offsets, field positions, reset values and per-instance capability words
 assumes a 10-bit byte address on the register bus
*/
`ifndef RIV_DEFINES_SVH
`define RIV_DEFINES_SVH
`define RIV_A_AIDR   10'h000
`define RIV_A_IIDR   10'h004
`define RIV_A_ECR    10'h008
`define RIV_A_ESR    10'h00C
`define RIV_A_PSEL   10'h010
`define RIV_A_FID    10'h014
`define RIV_A_CCAP   10'h018
`define RIV_A_CPOR   10'h01C
`define RIV_A_MON    10'h020
`define RIV_A_CSU    10'h024
`define RIV_A_MBWU   10'h028
`define RIV_A_IMPL   10'h02C
`define RIV_A_PRI    10'h030
`define RIV_A_MBW    10'h034
`define RIV_A_EN     10'h038
`define RIV_A_IMAP   10'h03C
`define RIV_A_WINWD  10'h040
`define RIV_A_EMSI   10'h044
`define RIV_A_CPBM   10'h100
`define RIV_A_PRISET 10'h104
`define RIV_A_MBWMAX 10'h108
`define RIV_AIDR_VAL 32'h0000_0011
`define RIV_IIDR_VAL 32'h0000_0ABC
`define RIV_RIS_MAX  4'h2
`define RIV_F_CCAP   0
`define RIV_F_CPOR   1
`define RIV_F_MBW    2
`define RIV_F_PRI    3
`define RIV_F_IMPL   4
`define RIV_F_MON    5
`define RIV_CAP0     8'hBB
`define RIV_CAP1     8'hC3
`define RIV_CAP2     8'h74
`define RIV_CCAP0    32'h3000_0408
`define RIV_CCAP1    32'h1000_0306
`define RIV_CPOR0    32'h0000_0010
`define RIV_CPOR1    32'h0000_0008
`define RIV_MON0     32'h0001_0000
`define RIV_MON2     32'h0002_0000
`define RIV_CSU0     32'h8000_0004
`define RIV_MBWU2    32'h8000_0002
`define RIV_IMPL0    32'h0000_00A0
`define RIV_IMPL2    32'h0000_00B2
`define RIV_PRI0     32'h0043_0081
`define RIV_MBW2     32'h0004_0010
`define RIV_ERR9     4'h9
`endif

// file: hdl/riv_pkg.sv
/*
 types of the resource-instance register view
 assumes riv_defines.svh is included by the design
*/
package riv_pkg;
	typedef logic [3:0] riv_ris_t;
	typedef logic [3:0] riv_pid_t;
	typedef struct packed {
		riv_ris_t instance_selector;
		riv_pid_t pid;
	} riv_psel_s;
	typedef struct packed {
		riv_ris_t code;
		riv_ris_t instance_selector;
		riv_pid_t pid;
	} riv_esr_s;
endpackage

// file: hdl/riv_regs.sv
/*
 resource-instance register view: classic wishbone slave
 assumes a single-cycle classic wishbone master and sec_ns_i valid with stb
*/
// Overview of operation
// - identification capability fields follow the instance selected in partition select.
// - cache, portion, monitor and bandwidth id fields return per-instance values.
// - top feature flags read 1 only if the selected instance has that feature.
// - no-impl monitor and partitioning flags follow the selected instance.
// - monitor id flags show the selected instance's storage and bandwidth monitors.
// - implementer feature word is specific to the selected instance.
// - priority widths and polarities are meaningless when their presence flag is 0.
// - priority partitioning is on instance 0 only here; other instances report priority zero.
// - global id, error and select registers ignore the instance selector.
// - partition select holds an instance selector and a partition id selector.
// - partition space of a configuration access follows the access security.
// - per-instance configuration registers reach the selected instance's settings.
// - enable, mapping, window and emsi controls are single component-wide settings; partition select has one copy per security space.
// - configuration access to a missing control records error code 9.
// - enable, mapping and window controls are reachable only with the instance selector at 0; emsi is reachable at any selector.
// - undefined instance reads all feature flags 0 and raises no error.
`timescale 1ns/1ps
`include "riv_defines.svh"
module riv_regs
	import riv_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        sec_ns_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	output logic             part_enable_o
);

////////////////////////////////////////////////////////////////////////////////
function automatic logic [7:0] cap(input riv_ris_t r);
	case (r)
		4'h0: cap = `RIV_CAP0;
		4'h1: cap = `RIV_CAP1;
		4'h2: cap = `RIV_CAP2;
		default: cap = 8'h00;
	endcase
endfunction

function automatic logic [31:0] id_word(input logic [9:0] a, input riv_ris_t r);
	logic [7:0] c;
	c = cap(r);
	id_word = 32'h0;
	case (a)
		`RIV_A_FID: id_word = {4'h0, `RIV_RIS_MAX, 16'h0, c};
		`RIV_A_CCAP: if (c[`RIV_F_CCAP]) begin
			id_word = (r == 4'h0) ? `RIV_CCAP0 : `RIV_CCAP1;
		end
		`RIV_A_CPOR: if (c[`RIV_F_CPOR]) begin
			id_word = (r == 4'h0) ? `RIV_CPOR0 : `RIV_CPOR1;
		end
		`RIV_A_MON: if (c[`RIV_F_MON]) begin
			id_word = (r == 4'h0) ? `RIV_MON0 : `RIV_MON2;
		end
		`RIV_A_CSU: if (c[`RIV_F_MON] && r == 4'h0) begin
			id_word = `RIV_CSU0;
		end
		`RIV_A_MBWU: if (c[`RIV_F_MON] && r == 4'h2) begin
			id_word = `RIV_MBWU2;
		end
		`RIV_A_IMPL: if (c[`RIV_F_IMPL]) begin
			id_word = (r == 4'h0) ? `RIV_IMPL0 : `RIV_IMPL2;
		end
		`RIV_A_PRI: if (c[`RIV_F_PRI]) begin
			id_word = `RIV_PRI0;
		end
		`RIV_A_MBW: if (c[`RIV_F_MBW]) begin
			id_word = `RIV_MBW2;
		end
		default: id_word = 32'h0;
	endcase
endfunction

function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
	input logic [3:0] s);
	for (int i = 0; i < 4; i++) begin
		wmask[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
logic            ack_r;
logic [31:0]     dat_r;
logic            ecr_r;
riv_esr_s        esr_r;
riv_esr_s        esr_nxt;
riv_psel_s       psel_r [0:1];
logic            en_r;
logic [15:0]     imap_r;
logic [15:0]     winwd_r;
logic [31:0]     emsi_r;
logic [15:0]     cpbm_m [0:127];
logic [15:0]     pri_m  [0:127];
logic [15:0]     mbw_m  [0:127];

wire             req     = wb_cyc_i & wb_stb_i & ~ack_r;
wire             wr      = req & wb_we_i;
wire             rd      = req & ~wb_we_i;
wire riv_psel_s  cur     = psel_r[sec_ns_i];
wire [7:0]       ccap    = cap(cur.instance_selector);
wire             defd    = cur.instance_selector <= `RIV_RIS_MAX;
wire             glb_ok  = cur.instance_selector == 4'h0;
wire [6:0]       idx     = {cur.instance_selector[1:0], sec_ns_i, cur.pid};
wire [31:0]      wdat    = wmask(32'h0, wb_dat_i, wb_sel_i);
wire             a_cpbm  = wb_adr_i == `RIV_A_CPBM;
wire             a_pri   = wb_adr_i == `RIV_A_PRISET;
wire             a_mbw   = wb_adr_i == `RIV_A_MBWMAX;
wire             a_cfg   = a_cpbm | a_pri | a_mbw;
wire             has_ctl = (a_cpbm & ccap[`RIV_F_CPOR]) | (a_pri & ccap[`RIV_F_PRI])
                         | (a_mbw & ccap[`RIV_F_MBW]);
wire             cfg_ok  = has_ctl & defd;
wire             cfg_bad = req & a_cfg & defd & ~has_ctl;
wire             esr_clr = wr & (wb_adr_i == `RIV_A_ESR);

////////////////////////////////////////////////////////////////////////////////
// read mux: id registers follow the selection of the access's own space
logic [31:0] rd_mux;
always_comb begin
	rd_mux = 32'h0;
	case (wb_adr_i)
		`RIV_A_AIDR:   rd_mux = `RIV_AIDR_VAL;
		`RIV_A_IIDR:   rd_mux = `RIV_IIDR_VAL;
		`RIV_A_ECR:    rd_mux = {31'h0, ecr_r};
		`RIV_A_ESR:    rd_mux = {20'h0, esr_r};
		`RIV_A_PSEL:   rd_mux = {4'h0, cur.instance_selector, 20'h0, cur.pid};
		`RIV_A_EN:     rd_mux = glb_ok ? {31'h0, en_r} : 32'h0;
		`RIV_A_IMAP:   rd_mux = glb_ok ? {16'h0, imap_r} : 32'h0;
		`RIV_A_WINWD:  rd_mux = glb_ok ? {16'h0, winwd_r} : 32'h0;
		`RIV_A_EMSI:   rd_mux = emsi_r;
		`RIV_A_CPBM:   rd_mux = cfg_ok ? {16'h0, cpbm_m[idx]} : 32'h0;
		`RIV_A_PRISET: rd_mux = cfg_ok ? {16'h0, pri_m[idx]} : 32'h0;
		`RIV_A_MBWMAX: rd_mux = cfg_ok ? {16'h0, mbw_m[idx]} : 32'h0;
		default:       rd_mux = id_word(wb_adr_i, cur.instance_selector);
	endcase
end

// a hardware error beats a software clear in the same cycle
always_comb begin
	esr_nxt = esr_r;
	if (esr_clr) begin
		esr_nxt = '0;
	end
	if (cfg_bad) begin
		esr_nxt = '{code: `RIV_ERR9, instance_selector: cur.instance_selector, pid: cur.pid};
	end
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		ack_r <= 1'b0;
		dat_r <= 32'h0;
	end else begin
		ack_r <= req;
		dat_r <= rd ? rd_mux : 32'h0;
	end
end

always_ff @(posedge clk_i) begin
	if (rst_i) begin
		ecr_r   <= 1'b0;
		esr_r   <= '0;
		psel_r  <= '{default: '0};
		en_r    <= 1'b0;
		imap_r  <= 16'h0;
		winwd_r <= 16'h0;
		emsi_r  <= 32'h0;
	end else begin
		esr_r <= esr_nxt;
		if (wr) begin
			case (wb_adr_i)
				`RIV_A_ECR:   ecr_r <= wb_sel_i[0] ? wb_dat_i[0] : ecr_r;
				`RIV_A_PSEL:  psel_r[sec_ns_i] <= {wdat[27:24], wdat[3:0]};
				`RIV_A_EN:    en_r <= glb_ok ? wdat[0] : en_r;
				`RIV_A_IMAP:  imap_r <= glb_ok ? wdat[15:0] : imap_r;
				`RIV_A_WINWD: winwd_r <= glb_ok ? wdat[15:0] : winwd_r;
				`RIV_A_EMSI:  emsi_r <= wmask(emsi_r, wb_dat_i, wb_sel_i);
				default:      ;
			endcase
		end
	end
end

always_ff @(posedge clk_i) begin
	if (wr && cfg_ok) begin
		if (a_cpbm) begin
			cpbm_m[idx] <= wdat[15:0];
		end
		if (a_pri) begin
			pri_m[idx] <= wdat[15:0];
		end
		if (a_mbw) begin
			mbw_m[idx] <= wdat[15:0];
		end
	end
end

assign wb_ack_o      = ack_r;
assign wb_dat_o      = dat_r;
assign part_enable_o = en_r;

////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);

// access seen in the previous cycle, lined up with the registered answer
logic           p_rd;
logic           p_wr;
logic           p_cfg;
logic           p_ok;
logic [9:0]     p_adr;
riv_psel_s      p_sel;
always_ff @(posedge clk_i) begin
	p_rd  <= rd;
	p_wr  <= wr;
	p_cfg <= a_cfg;
	p_ok  <= cfg_ok;
	p_adr <= wb_adr_i;
	p_sel <= cur;
end

////////////////////////////////////////////////////////////////////////////////
// bus answer
ack_pulse_a: assert property (ack_r |=> !ack_r)
	else $error("ack held longer than one cycle");
ack_next_a: assert property (req
	|=> wb_ack_o)
	else $error("request not answered in the next cycle");
wr_zero_a: assert property (p_wr
	|-> wb_ack_o && wb_dat_o == 32'h0)
	else $error("write answered without ack or with data");

// selection
sel_write_a: assert property (wr && wb_adr_i == `RIV_A_PSEL && wb_sel_i == 4'hF
	|=> psel_r[$past(sec_ns_i)] == {$past(wb_dat_i[27:24]), $past(wb_dat_i[3:0])})
	else $error("partition select not updated");
sel_other_a: assert property (wr && wb_adr_i == `RIV_A_PSEL && !sec_ns_i
	|=> $stable(psel_r[1]))
	else $error("secure select write touched the non-secure copy");

// identification words
feat_read_a: assert property (p_rd && p_adr == `RIV_A_FID
	|-> wb_dat_o[7:0] == cap(p_sel.instance_selector))
	else $error("feature flags do not follow selected instance");
fid_max_a: assert property (p_rd && p_adr == `RIV_A_FID
	|-> wb_dat_o[27:24] == `RIV_RIS_MAX)
	else $error("largest instance field wrong");
undef_id_a: assert property (rd && wb_adr_i == `RIV_A_FID && cur.instance_selector > `RIV_RIS_MAX
	|=> wb_dat_o[7:0] == 8'h00 && $stable(esr_r))
	else $error("undefined instance shows features or error");
mon_flag_a: assert property (p_rd && p_adr == `RIV_A_MON && p_sel.instance_selector == 4'h1
	|-> wb_dat_o == 32'h0)
	else $error("monitor flags shown for instance without monitors");
pri_zero_a: assert property (p_rd && p_adr == `RIV_A_PRI && p_sel.instance_selector != 4'h0
	|-> wb_dat_o == 32'h0)
	else $error("priority id nonzero off instance zero");
impl_id_a: assert property (p_rd && p_adr == `RIV_A_IMPL && p_sel.instance_selector == 4'h1
	|-> wb_dat_o == 32'h0)
	else $error("implementer word shown for instance without it");
mbwu_id_a: assert property (p_rd && p_adr == `RIV_A_MBWU && p_sel.instance_selector != 4'h2
	|-> wb_dat_o == 32'h0)
	else $error("bandwidth monitor id shown for wrong instance");
csu_id_a: assert property (p_rd && p_adr == `RIV_A_CSU && p_sel.instance_selector != 4'h0
	|-> wb_dat_o == 32'h0)
	else $error("storage monitor id shown for wrong instance");
ccap_id_a: assert property (p_rd && p_adr == `RIV_A_CCAP && p_sel.instance_selector > 4'h1
	|-> wb_dat_o == 32'h0)
	else $error("cache capacity id shown for wrong instance");
aidr_free_a: assert property (p_rd && p_adr == `RIV_A_AIDR
	|-> wb_dat_o == `RIV_AIDR_VAL)
	else $error("architecture id depends on selector");
iidr_free_a: assert property (p_rd && p_adr == `RIV_A_IIDR
	|-> wb_dat_o == `RIV_IIDR_VAL)
	else $error("implementation id depends on selector");
ecr_free_a: assert property (p_rd && p_adr == `RIV_A_ECR
	|-> wb_dat_o == {31'h0, ecr_r})
	else $error("error control read depends on selector");

// global and configuration controls
glb_gate_a: assert property (wr && wb_adr_i == `RIV_A_EN && cur.instance_selector != 4'h0
	|=> $stable(part_enable_o) [*2])
	else $error("global enable written with nonzero selector");
glb_read_a: assert property (p_rd && p_adr == `RIV_A_EN && p_sel.instance_selector != 4'h0
	|-> wb_dat_o == 32'h0)
	else $error("global enable readable with nonzero selector");
glb_hold_a: assert property (wr && !glb_ok
	&& (wb_adr_i == `RIV_A_IMAP || wb_adr_i == `RIV_A_WINWD)
	|=> $stable(imap_r) && $stable(winwd_r))
	else $error("global mapping or window written with nonzero selector");
cfg_zero_a: assert property (p_rd && p_cfg && !p_ok
	|-> wb_dat_o == 32'h0)
	else $error("missing control read returned data");
undef_cfg_a: assert property (req && a_cfg && !defd
	|=> $stable(esr_r))
	else $error("undefined instance access recorded an error");
err_nine_a: assert property (cfg_bad
	|=> esr_r.code == `RIV_ERR9 ##1 esr_r.code == `RIV_ERR9 || $past(esr_clr))
	else $error("missing control access not recorded");
esr_clear_a: assert property (esr_clr && !cfg_bad
	|=> esr_r == '0)
	else $error("error status not cleared by write");

sel_then_id_c: cover property (wr && wb_adr_i == `RIV_A_PSEL
	##[1:4] rd && wb_adr_i == `RIV_A_FID);
cfg_write_c:   cover property (wr && cfg_ok && a_cpbm);
err_nine_c:    cover property (cfg_bad);
undef_read_c:  cover property (rd && wb_adr_i == `RIV_A_FID && !defd);
part_sel_c:    cover property (wr && wb_sel_i != 4'hF);
endmodule

// file: test/resource_instance_register_view_test.sv
/*
 self-checking bench of the resource-instance register view
 assumes riv_regs answers each classic wishbone request with a one-cycle ack
*/
`timescale 1ns/1ps
`include "riv_defines.svh"
module resource_instance_register_view_test
	import riv_pkg::*;
;
	typedef struct packed {
		riv_ris_t    instance_selector;
		logic [9:0]  adr;
		logic [31:0] exp;
	} riv_row_s;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [9:0]  wb_adr_i = 10'h000;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [3:0]  sel = 4'hF;
	logic        sec_ns_i = 1'b0;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	logic        part_enable_o;
	logic        ns = 1'b0;
	logic [31:0] rd;
	logic [31:0] m;
	int          miscompares = 0;
	int          checked = 0;
	riv_row_s    rows [24] = '{
		'{4'h0, `RIV_A_FID, {8'h0, 16'h0, `RIV_CAP0} | 32'h0200_0000},
		'{4'h1, `RIV_A_FID, {8'h0, 16'h0, `RIV_CAP1} | 32'h0200_0000},
		'{4'h2, `RIV_A_FID, {8'h0, 16'h0, `RIV_CAP2} | 32'h0200_0000},
		'{4'h3, `RIV_A_FID, 32'h0}, '{4'hF, `RIV_A_FID, 32'h0},
		'{4'h0, `RIV_A_CCAP, `RIV_CCAP0}, '{4'h1, `RIV_A_CCAP, `RIV_CCAP1},
		'{4'h2, `RIV_A_CCAP, 32'h0}, '{4'h0, `RIV_A_CPOR, `RIV_CPOR0},
		'{4'h1, `RIV_A_CPOR, `RIV_CPOR1}, '{4'h2, `RIV_A_CPOR, 32'h0},
		'{4'h0, `RIV_A_MON, `RIV_MON0}, '{4'h1, `RIV_A_MON, 32'h0},
		'{4'h2, `RIV_A_MON, `RIV_MON2}, '{4'h0, `RIV_A_CSU, `RIV_CSU0},
		'{4'h2, `RIV_A_MBWU, `RIV_MBWU2}, '{4'h0, `RIV_A_IMPL, `RIV_IMPL0},
		'{4'h1, `RIV_A_IMPL, 32'h0}, '{4'h2, `RIV_A_IMPL, `RIV_IMPL2},
		'{4'h0, `RIV_A_PRI, `RIV_PRI0}, '{4'h2, `RIV_A_PRI, 32'h0},
		'{4'h2, `RIV_A_MBW, `RIV_MBW2}, '{4'h2, `RIV_A_AIDR, `RIV_AIDR_VAL},
		'{4'h7, `RIV_A_IIDR, `RIV_IIDR_VAL}
	};

	riv_regs dut (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.wb_cyc_i      (wb_cyc_i),
		.wb_stb_i      (wb_stb_i),
		.wb_we_i       (wb_we_i),
		.wb_adr_i      (wb_adr_i),
		.wb_sel_i      (wb_sel_i),
		.wb_dat_i      (wb_dat_i),
		.sec_ns_i      (sec_ns_i),
		.wb_ack_o      (wb_ack_o),
		.wb_dat_o      (wb_dat_o),
		.part_enable_o (part_enable_o)
	);

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one classic cycle; request held until ack is seen at a rising edge, released there
	task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel;
		sec_ns_i <= ns;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			miscompares++;
			stop_test();
		end
	endtask

	task automatic psel(input riv_ris_t r, input riv_pid_t p);
		logic [31:0] q;
		wb(1'b1, `RIV_A_PSEL, {4'h0, r, 20'h0, p}, q);
	endtask

	task automatic rdc(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		cmp(q, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp(wb_dat_o, 32'h0);
		cmp({30'h0, wb_ack_o, part_enable_o}, 32'h0);
		foreach (rows[i]) begin
			psel(rows[i].instance_selector, 4'(i));
			rdc(`RIV_A_PSEL, {4'h0, rows[i].instance_selector, 20'h0, 4'(i)});
			wb(1'b0, rows[i].adr, 32'h0, rd);
			m = (rows[i].instance_selector > `RIV_RIS_MAX && rows[i].adr == `RIV_A_FID) ? 32'hFF : '1;
			cmp(rd & m, rows[i].exp);
		end
		rdc(10'h3FC, 32'h0);
		psel(4'h0, 4'h1);
		wb(1'b1, `RIV_A_PRISET, 32'h1234, rd);
		ns = 1'b1;
		psel(4'h0, 4'h1);
		wb(1'b1, `RIV_A_PRISET, 32'h5678, rd);
		ns = 1'b0;
		rdc(`RIV_A_PRISET, 32'h1234);
		ns = 1'b1;
		rdc(`RIV_A_PRISET, 32'h5678);
		ns = 1'b0;
		wb(1'b1, `RIV_A_CPBM, 32'h00F0, rd);
		psel(4'h1, 4'h1);
		wb(1'b1, `RIV_A_CPBM, 32'h000F, rd);
		rdc(`RIV_A_CPBM, 32'h000F);
		psel(4'h0, 4'h1);
		rdc(`RIV_A_CPBM, 32'h00F0);
		psel(4'h0, 4'h2);
		wb(1'b1, `RIV_A_MBWMAX, 32'h0055, rd);
		rdc(`RIV_A_MBWMAX, 32'h0);
		rdc(`RIV_A_ESR, {20'h0, `RIV_ERR9, 4'h0, 4'h2});
		wb(1'b1, `RIV_A_ESR, 32'h0, rd);
		rdc(`RIV_A_ESR, 32'h0);
		psel(4'h2, 4'h2);
		wb(1'b1, `RIV_A_MBWMAX, 32'h0055, rd);
		rdc(`RIV_A_MBWMAX, 32'h0055);
		psel(4'h3, 4'h1);
		rdc(`RIV_A_PRISET, 32'h0);
		rdc(`RIV_A_ESR, 32'h0);
		psel(4'h0, 4'h0);
		wb(1'b1, `RIV_A_EN, 32'h1, rd);
		@(negedge clk_i);
		cmp({31'h0, part_enable_o}, 32'h1);
		psel(4'h1, 4'h0);
		wb(1'b1, `RIV_A_EN, 32'h0, rd);
		@(negedge clk_i);
		cmp({31'h0, part_enable_o}, 32'h1);
		rdc(`RIV_A_EN, 32'h0);
		psel(4'h0, 4'h0);
		rdc(`RIV_A_EN, 32'h1);
		wb(1'b1, `RIV_A_IMAP, 32'h0000_1234, rd);
		wb(1'b1, `RIV_A_WINWD, 32'h0000_00FF, rd);
		psel(4'h2, 4'h0);
		wb(1'b1, `RIV_A_IMAP, 32'h0000_BEEF, rd);
		rdc(`RIV_A_IMAP, 32'h0);
		wb(1'b1, `RIV_A_ECR, 32'h1, rd);
		rdc(`RIV_A_ECR, 32'h1);
		wb(1'b1, `RIV_A_EMSI, 32'hAABB_CCDD, rd);
		sel = 4'h1;
		wb(1'b1, `RIV_A_EMSI, 32'h1122_3344, rd);
		sel = 4'hF;
		rdc(`RIV_A_EMSI, 32'hAABB_CC44);
		psel(4'h0, 4'h0);
		rdc(`RIV_A_IMAP, 32'h0000_1234);
		rdc(`RIV_A_WINWD, 32'h0000_00FF);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp({31'h0, part_enable_o}, 32'h0);
		ns = 1'b1;
		rdc(`RIV_A_PSEL, 32'h0);
		ns = 1'b0;
		stop_test();
	end
endmodule
